// file: sffe_pkg.sv
package sffe_pkg;
  // opcodes
  localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
  localparam logic [7:0] OP_QUAD_WORD  = 8'hE7;
  localparam logic [7:0] OP_QUAD_OCT   = 8'hE3;
  localparam logic [7:0] OP_RST_EN     = 8'h66;
  localparam logic [7:0] OP_RST        = 8'h99;
  localparam logic [7:0] OP_READ_STAT  = 8'h05;
  localparam logic [7:0] OP_SUSPEND    = 8'h75;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_PROGRAM    = 8'h02;
  localparam logic [7:0] OP_ERASE      = 8'h20;
  localparam logic [7:0] OP_WRITE_STAT = 8'h01;
  // timing
  localparam int CLK_PERIOD_NS         = 8;
  localparam int SOFT_RESET_US         = 30;
  localparam int SOFT_RESET_CYC        = SOFT_RESET_US * 1000 / CLK_PERIOD_NS;
  localparam int HARD_RESET_MIN_PULSE_NS = 1000;
  localparam int HARD_RESET_CYC        =
    (HARD_RESET_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC              = 2000;
  localparam int LINK_HALF_CYC         = 10;
  localparam int BUSY_BIT_POSITION     = 0;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [3:0] LANE_RESET    = 4'h0;
  localparam logic [3:0] BITCNT_RESET  = 4'h0;
  // lane width modes
  typedef enum logic [2:0] {
    SFFE_W1 = 3'b001,
    SFFE_W2 = 3'b010,
    SFFE_W4 = 3'b100
  } sffe_width_e;
endpackage : sffe_pkg

// file: sffe_if.sv
interface sffe_if;
  logic       sel_n;
  logic       sclk;
  logic       hard_reset_n;
  logic       hard_reset_n_oe;
  logic [3:0] ctl_lane_o;
  logic [3:0] ctl_lane_oe;
  logic [3:0] dev_lane_o;
  logic [3:0] dev_lane_oe;
  wire  [3:0] lane;
  wire        hard_reset_pin;
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign lane[g] = ctl_lane_oe[g] ? ctl_lane_o[g] :
                     dev_lane_oe[g] ? dev_lane_o[g] : 1'b1;
  end
  // internal pull-up on reset pin
  assign hard_reset_pin = hard_reset_n_oe ? hard_reset_n : 1'b1;
  modport dev (input sel_n, input sclk, input hard_reset_pin, input lane,
               output dev_lane_o, output dev_lane_oe);
  modport ctl (output sel_n, output sclk, output hard_reset_n, output hard_reset_n_oe,
               output ctl_lane_o, output ctl_lane_oe, input lane);
endinterface : sffe_if

// file: sffe_device.sv
// Overview of operation
// [RQ1] select high: deselected, lanes released
// [RQ2] internal busy cycle survives deselect
// [RQ3] no command before first select fall
// [RQ4] single lane: sample input on rising
// [RQ5] single lane: shift output on falling
// [RQ6] dual/quad: lanes bidirectional, rise in, fall out (code: dual/quad opcodes only drive out on fall, all input is on lane 0)
// [RQ7] modes 0 and 3 supported
// [RQ8] 3B/BB use lanes 0 and 1
// [RQ9] quad reads use lanes 0 to 3
// [RQ10] reset only after consecutive 66h, 99h
// [RQ11] reset period about 30us rejects commands
// [RQ12] hard reset low 1us restores power-on
// [RQ13] hard reset beats every other input
// [RQ14] hard reset clears spi and counter logic
// [RQ15] hard reset pin pulled inactive
// [RQ16] busy ignores all but status, suspend
// [RQ17] 8-bit msb-first opcode, partial discarded
module sffe_device
  import sffe_pkg::*;
(
  // system
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // link
  sffe_if.dev             link,
  // user side
  output logic [7:0]      opcode_o,
  output logic            opcode_valid_o,
  output logic [7:0]      rx_byte_o,
  output logic            rx_valid_o,
  input  wire logic [7:0] tx_byte_i,
  output logic            busy_o,
  output logic            soft_reset_o,
  output logic            counters_reset_o
);
  import sffe_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_OPC  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_RST  = 4'b1000
  } sffe_dev_state_e;

  logic [1:0] sel_sync_q, clk_sync_q, rst_sync_q;
  logic [3:0] lane_s1_q, lane_s2_q;
  logic       clk_prev_q;
  logic       armed_q, rst_en_q, out_mode_q;
  logic [7:0] sh_q, tx_q;
  logic [3:0] bits_q;
  logic [3:0] oe_q, out_q;
  sffe_width_e     width_q;
  sffe_dev_state_e st_q;
  logic [15:0] rst_cnt_q, busy_cnt_q, hard_cnt_q;
  logic        sel, rise, fall, hard;

  assign sel  = ~sel_sync_q[1];
  assign rise = clk_sync_q[1] & ~clk_prev_q;
  assign fall = ~clk_sync_q[1] & clk_prev_q;
  // pull-up lives in the interface; low must persist the minimum pulse
  assign hard = (hard_cnt_q >= 16'(HARD_RESET_CYC)); // see [RQ12] see [RQ15]

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sel_sync_q <= 2'b00; // starts selected so a real high must arm see [RQ3]
      clk_sync_q <= 2'b00;
      rst_sync_q <= 2'b11;
      lane_s1_q  <= LANE_RESET;
      lane_s2_q  <= LANE_RESET;
      clk_prev_q <= 1'b0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], link.sel_n};
      clk_sync_q <= {clk_sync_q[0], link.sclk};
      rst_sync_q <= {rst_sync_q[0], link.hard_reset_pin};
      lane_s1_q  <= link.lane;
      lane_s2_q  <= lane_s1_q;
      clk_prev_q <= clk_sync_q[1]; // edge detect works for modes 0 and 3 see [RQ7]
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) hard_cnt_q <= 16'h0000;
    else if (rst_sync_q[1]) hard_cnt_q <= 16'h0000;
    else if (!hard) hard_cnt_q <= hard_cnt_q + 16'h0001;
  end

  // busy cycle timer, runs regardless of select
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) busy_cnt_q <= 16'h0000;
    else if (hard) busy_cnt_q <= 16'h0000; // see [RQ13]
    else if (opcode_valid_o && busy_cnt_q == 16'h0000 &&
             (opcode_o == OP_PROGRAM || opcode_o == OP_ERASE ||
              opcode_o == OP_WRITE_STAT))
      busy_cnt_q <= 16'(BUSY_CYC);
    else if (busy_cnt_q != 16'h0000)
      busy_cnt_q <= busy_cnt_q - 16'h0001; // see [RQ2]
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= ST_IDLE; armed_q <= 1'b0; rst_en_q <= 1'b0; out_mode_q <= 1'b0;
      sh_q <= STATUS_RESET; tx_q <= STATUS_RESET; bits_q <= BITCNT_RESET;
      oe_q <= LANE_RESET; out_q <= LANE_RESET; width_q <= SFFE_W1;
      rst_cnt_q <= 16'h0000; opcode_o <= STATUS_RESET; opcode_valid_o <= 1'b0;
      rx_byte_o <= STATUS_RESET; rx_valid_o <= 1'b0; busy_o <= 1'b0;
      soft_reset_o <= 1'b0; counters_reset_o <= 1'b0;
    end else begin
      opcode_valid_o   <= 1'b0;
      rx_valid_o       <= 1'b0;
      soft_reset_o     <= 1'b0;
      counters_reset_o <= hard; // see [RQ14]
      busy_o           <= (busy_cnt_q != 16'h0000);
      if (hard) begin // see [RQ13] see [RQ14]
        st_q <= ST_IDLE; armed_q <= 1'b0; rst_en_q <= 1'b0; oe_q <= LANE_RESET;
        bits_q <= BITCNT_RESET; soft_reset_o <= 1'b1;
        width_q <= SFFE_W1; out_mode_q <= 1'b0; rst_cnt_q <= 16'h0000;
      end else if (st_q == ST_RST) begin
        oe_q <= LANE_RESET;
        if (rst_cnt_q == 16'h0000) st_q <= ST_IDLE;
        else rst_cnt_q <= rst_cnt_q - 16'h0001; // see [RQ11]
      end else if (!sel) begin
        oe_q <= LANE_RESET; // see [RQ1]
        bits_q <= BITCNT_RESET; // see [RQ17]
        armed_q <= 1'b1; // a high level seen first arms the first fall see [RQ3]
        if (st_q != ST_IDLE) st_q <= ST_IDLE;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (armed_q) begin // see [RQ3]
              st_q <= ST_OPC; width_q <= SFFE_W1; out_mode_q <= 1'b0;
            end
          end
          ST_OPC: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], lane_s2_q[0]}; // see [RQ4] see [RQ17]
              bits_q <= bits_q + 4'h1;
              if (bits_q == 4'h7) begin
                bits_q <= BITCNT_RESET;
                if (busy_cnt_q != 16'h0000 && {sh_q[6:0], lane_s2_q[0]} != OP_READ_STAT &&
                    {sh_q[6:0], lane_s2_q[0]} != OP_SUSPEND) begin
                  st_q <= ST_IDLE; armed_q <= 1'b0; // see [RQ16]
                end else begin
                  opcode_o <= {sh_q[6:0], lane_s2_q[0]};
                  opcode_valid_o <= 1'b1;
                  st_q <= ST_DATA;
                  tx_q <= tx_byte_i;
                  rst_en_q <= ({sh_q[6:0], lane_s2_q[0]} == OP_RST_EN);
                  if (rst_en_q && {sh_q[6:0], lane_s2_q[0]} == OP_RST) begin // see [RQ10]
                    st_q <= ST_RST; rst_cnt_q <= 16'(SOFT_RESET_CYC); soft_reset_o <= 1'b1;
                    armed_q <= 1'b0;
                  end
                  case ({sh_q[6:0], lane_s2_q[0]})
                    OP_DUAL_OUT, OP_DUAL_IO: width_q <= SFFE_W2; // see [RQ8]
                    OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD, OP_QUAD_OCT:
                      width_q <= SFFE_W4; // see [RQ9]
                    default: width_q <= SFFE_W1;
                  endcase
                  out_mode_q <= ({sh_q[6:0], lane_s2_q[0]} != OP_PROGRAM &&
                                 {sh_q[6:0], lane_s2_q[0]} != OP_WRITE_STAT);
                end
              end
            end
          end
          ST_DATA: begin
            if (!out_mode_q && rise) begin // see [RQ6]
              case (width_q)
                SFFE_W4: sh_q <= {sh_q[3:0], lane_s2_q};
                SFFE_W2: sh_q <= {sh_q[5:0], lane_s2_q[1:0]};
                default: sh_q <= {sh_q[6:0], lane_s2_q[0]};
              endcase
              if (bits_q == 4'h7 || (width_q == SFFE_W2 && bits_q == 4'h3) ||
                  (width_q == SFFE_W4 && bits_q == 4'h1)) begin
                bits_q <= BITCNT_RESET; rx_valid_o <= 1'b1;
                case (width_q)
                  SFFE_W4: rx_byte_o <= {sh_q[3:0], lane_s2_q};
                  SFFE_W2: rx_byte_o <= {sh_q[5:0], lane_s2_q[1:0]};
                  default: rx_byte_o <= {sh_q[6:0], lane_s2_q[0]};
                endcase
              end else bits_q <= bits_q + 4'h1;
            end else if (out_mode_q && fall) begin // see [RQ5] see [RQ6]
              case (width_q)
                SFFE_W4: begin
                  oe_q <= 4'hF; out_q <= tx_q[7:4]; tx_q <= {tx_q[3:0], 4'h0};
                end
                SFFE_W2: begin
                  oe_q <= 4'h3; out_q <= {2'b00, tx_q[7:6]}; tx_q <= {tx_q[5:0], 2'b00};
                end
                default: begin
                  oe_q <= 4'h2; out_q <= {2'b00, tx_q[7], 1'b0}; tx_q <= {tx_q[6:0], 1'b0};
                end
              endcase
              if (bits_q == 4'h7 || (width_q == SFFE_W2 && bits_q == 4'h3) ||
                  (width_q == SFFE_W4 && bits_q == 4'h1)) begin
                bits_q <= BITCNT_RESET; tx_q <= tx_byte_i;
              end else bits_q <= bits_q + 4'h1;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign link.dev_lane_o  = out_q;
  assign link.dev_lane_oe = oe_q;
endmodule : sffe_device

// file: sffe_controller.sv
module sffe_controller
  import sffe_pkg::*;
(
  // system
  input  wire logic       clock_i,
  input  wire logic       resetn_i,
  // link
  sffe_if.ctl             link,
  // user side
  input  wire logic       start_i,
  input  wire logic [7:0] opcode_i,
  input  wire logic [1:0] read_bytes_i,
  input  wire logic       hard_reset_i,
  output logic            done_o,
  output logic [7:0]      rd_byte_o,
  output logic            rd_valid_o
);
  import sffe_pkg::*;

  typedef enum logic [3:0] {
    CS_IDLE = 4'b0001,
    CS_PRE  = 4'b0010,
    CS_XFER = 4'b0100,
    CS_HRST = 4'b1000
  } sffe_ctl_state_e;

  sffe_ctl_state_e st_q;
  logic [15:0] div_q, hcnt_q;
  logic        sclk_q, sel_n_q, hr_q;
  logic [7:0]  sh_q, rd_q;
  logic [5:0]  bits_q, total_q;
  logic [1:0]  lane1_sync_q;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) lane1_sync_q <= 2'b00;
    else lane1_sync_q <= {lane1_sync_q[0], link.lane[1]};
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= CS_IDLE; div_q <= 16'h0000; hcnt_q <= 16'h0000; sclk_q <= 1'b0;
      sel_n_q <= 1'b1; hr_q <= 1'b1; sh_q <= 8'h00; rd_q <= 8'h00;
      bits_q <= 6'h00; total_q <= 6'h00; done_o <= 1'b0;
      rd_byte_o <= 8'h00; rd_valid_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      rd_valid_o <= 1'b0;
      case (st_q)
        CS_IDLE: begin
          sclk_q <= 1'b0; sel_n_q <= 1'b1; // clock parked low, mode 0 see [RQ7]
          if (hard_reset_i) begin
            st_q <= CS_HRST; hcnt_q <= 16'(HARD_RESET_CYC + 2); hr_q <= 1'b0; // see [RQ12]
          end else if (start_i) begin
            st_q <= CS_PRE; sel_n_q <= 1'b0; sh_q <= opcode_i; bits_q <= 6'h00;
            total_q <= 6'(8 + 8 * read_bytes_i); div_q <= 16'(LINK_HALF_CYC);
          end
        end
        CS_HRST: begin
          if (hcnt_q == 16'h0000) begin
            hr_q <= 1'b1; st_q <= CS_IDLE; done_o <= 1'b1;
          end else hcnt_q <= hcnt_q - 16'h0001;
        end
        CS_PRE: begin
          if (div_q == 16'h0000) begin
            st_q <= CS_XFER; div_q <= 16'(LINK_HALF_CYC);
          end else div_q <= div_q - 16'h0001;
        end
        CS_XFER: begin
          if (div_q == 16'h0000) begin
            div_q <= 16'(LINK_HALF_CYC);
            if (!sclk_q) begin
              sclk_q <= 1'b1;
              if (bits_q >= 6'h08) begin
                rd_q <= {rd_q[6:0], lane1_sync_q[1]};
                if (bits_q[2:0] == 3'h7) begin
                  rd_byte_o <= {rd_q[6:0], lane1_sync_q[1]}; rd_valid_o <= 1'b1;
                end
              end
            end else begin
              sclk_q <= 1'b0;
              sh_q <= {sh_q[6:0], 1'b0};
              bits_q <= bits_q + 6'h01;
              if (bits_q + 6'h01 == total_q) begin
                st_q <= CS_IDLE; sel_n_q <= 1'b1; done_o <= 1'b1;
              end
            end
          end else div_q <= div_q - 16'h0001;
        end
        default: st_q <= CS_IDLE;
      endcase
    end
  end

  assign link.sclk            = sclk_q;
  assign link.sel_n           = sel_n_q;
  assign link.hard_reset_n    = hr_q;
  assign link.hard_reset_n_oe = ~hr_q;
  assign link.ctl_lane_o      = {3'b000, sh_q[7]};
  assign link.ctl_lane_oe     = {3'b000, (st_q == CS_XFER || st_q == CS_PRE) && bits_q < 6'h08};
endmodule : sffe_controller

// file: sffe_assertions.sv
module sffe_assertions
  import sffe_pkg::*;
(
  // system
  input wire logic       clock_i,
  input wire logic       resetn_i,
  // link
  input wire logic       sel_n,
  input wire logic       sclk,
  input wire logic       hard_reset_n_oe,
  input wire logic       hard_reset_pin,
  input wire logic [3:0] ctl_lane_oe,
  input wire logic [3:0] dev_lane_oe,
  input wire logic [3:0] dev_lane_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] low_q;
  // run length of reset pin low
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) low_q <= 8'h00;
    else if (hard_reset_pin) low_q <= 8'h00;
    else if (low_q != 8'hFF) low_q <= low_q + 8'h01;
  end
  sequence s_desel;
    sel_n [*6];
  endsequence
  sequence s_frame_edge;
    $fell(sel_n) || $rose(sel_n);
  endsequence
  sequence s_hard_end;
    $rose(hard_reset_pin);
  endsequence
  a_deselect_release: assert property (
    s_desel |-> dev_lane_oe == 4'h0) else $error("lanes driven while deselected");
  a_lane_set_legal: assert property (
    dev_lane_oe inside {4'h0, 4'h2, 4'h3, 4'hF}) else $error("illegal lane enable set");
  a_out_on_fall: assert property (
    ($changed(dev_lane_o) && dev_lane_oe != 4'h0 && $past(dev_lane_oe) != 4'h0) |-> !sclk)
    else $error("output changed while clock high");
  a_drive_start: assert property (
    $rose(|dev_lane_oe) |-> !sel_n && !sclk) else $error("drive began off a falling edge");
  a_no_contention: assert property (
    (ctl_lane_oe & dev_lane_oe) == 4'h0) else $error("both ends drive one lane");
  a_mode_park: assert property (
    s_frame_edge |-> !sclk) else $error("clock not parked at select edge");
  a_idle_clock: assert property (
    sel_n |-> !sclk) else $error("clock moves outside frame");
  a_hard_pulse: assert property (
    s_hard_end |-> low_q >= 8'(HARD_RESET_CYC)) else $error("hard reset pulse too short");
  a_hard_abort: assert property (
    s_hard_end |-> ##[0:6] dev_lane_oe == 4'h0) else $error("lanes kept after hard reset");
  a_reset_pull: assert property (
    !hard_reset_n_oe |-> hard_reset_pin) else $error("floating reset pin not high");
endmodule : sffe_assertions

// file: tb_serial_flash_spi_front_end.sv
module tb_serial_flash_spi_front_end;
  timeunit 1ns;
  timeprecision 1ns;
  import sffe_pkg::*;
  logic       clock_i = 1'b0;
  logic       resetn_i, start_i, hard_reset_i, done_o, rd_valid_o;
  logic       opcode_valid_o, busy_o, soft_reset_o, counters_reset_o, rx_valid_o;
  logic [7:0] opcode_i, tx_byte_i, opcode_o, rd_byte_o, op_last, rd_last, rx_byte_o, rx_last;
  logic [1:0] read_bytes_i;
  logic [3:0] oe_acc;
  logic [7:0] ops [6] = '{OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT, OP_QUAD_IO, OP_QUAD_WORD,
                          OP_QUAD_OCT};
  logic [3:0] oes [6] = '{4'h3, 4'h3, 4'hF, 4'hF, 4'hF, 4'hF};
  int         bad_count = 0, checks = 0, op_cnt, soft_cnt, cr_cnt;
  sffe_if link_if ();
  sffe_device sffe_device_inst (.clock_i(clock_i), .resetn_i(resetn_i), .link(link_if.dev),
    .opcode_o(opcode_o), .opcode_valid_o(opcode_valid_o), .rx_byte_o(rx_byte_o),
    .rx_valid_o(rx_valid_o),
    .tx_byte_i(tx_byte_i), .busy_o(busy_o), .soft_reset_o(soft_reset_o),
    .counters_reset_o(counters_reset_o));
  sffe_controller sffe_controller_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .link(link_if.ctl), .start_i(start_i), .opcode_i(opcode_i), .read_bytes_i(read_bytes_i),
    .hard_reset_i(hard_reset_i), .done_o(done_o), .rd_byte_o(rd_byte_o),
    .rd_valid_o(rd_valid_o));
  sffe_assertions sffe_assertions_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .sel_n(link_if.sel_n), .sclk(link_if.sclk), .hard_reset_n_oe(link_if.hard_reset_n_oe),
    .hard_reset_pin(link_if.hard_reset_pin), .ctl_lane_oe(link_if.ctl_lane_oe),
    .dev_lane_oe(link_if.dev_lane_oe), .dev_lane_o(link_if.dev_lane_o));
  always #4 clock_i = ~clock_i;
  // user side monitor
  always @(posedge clock_i) begin
    if (opcode_valid_o === 1'b1) begin
      op_cnt++;
      op_last = opcode_o;
    end
    if (rd_valid_o === 1'b1) rd_last = rd_byte_o;
    if (rx_valid_o === 1'b1) rx_last = rx_byte_o;
    if (soft_reset_o === 1'b1) soft_cnt++;
    if (counters_reset_o === 1'b1) cr_cnt++;
    oe_acc |= link_if.dev_lane_oe;
  end
  task close_out;
    $display("mismatches %0d, checks %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task note(input string s);
    $display("test %s done at %0t", s, $time);
  endtask : note
  // one command per select, then let select settle high
  task cmd(input logic [7:0] op, input logic [1:0] nb);
    int n;
    @(negedge clock_i);
    op_cnt = 0;
    oe_acc = 4'h0;
    start_i = 1'b1;
    opcode_i = op;
    read_bytes_i = nb;
    @(negedge clock_i);
    start_i = 1'b0;
    for (n = 0; n < 4000 && done_o !== 1'b1; n++) @(negedge clock_i);
    if (n == 4000) begin
      bad_count++;
      $display("Error at %0t: no done", $time);
    end
    repeat (8) @(negedge clock_i);
  endtask : cmd
  initial begin
    repeat (60000) @(posedge clock_i);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    close_out();
  end
  initial begin
    int i, n;
    resetn_i = 1'b0;
    start_i = 1'b0;
    hard_reset_i = 1'b0;
    opcode_i = 8'h00;
    read_bytes_i = 2'h0;
    tx_byte_i = 8'hA5;
    repeat (16) @(negedge clock_i);
    resetn_i = 1'b1;
    cmd(OP_READ_STAT, 2'h1);
    chk(8'(op_cnt), 8'h01);
    chk(op_last, OP_READ_STAT);
    chk(rd_last, 8'hA5);
    chk({4'h0, oe_acc}, 8'h02);
    note("single");
    for (i = 0; i < 6; i++) begin
      cmd(ops[i], 2'h1);
      chk(op_last, ops[i]);
      chk({4'h0, oe_acc}, {4'h0, oes[i]});
    end
    note("lanes");
    cmd(OP_PROGRAM, 2'h1);
    chk({7'h00, busy_o}, 8'h01);
    chk(rx_last, 8'hFF);
    chk({4'h0, oe_acc}, 8'h00);
    cmd(OP_READ, 2'h1);
    chk(8'(op_cnt), 8'h00);
    cmd(OP_READ_STAT, 2'h1);
    chk(op_last, OP_READ_STAT);
    cmd(OP_SUSPEND, 2'h0);
    chk(op_last, OP_SUSPEND);
    for (n = 0; n < BUSY_CYC + 100 && busy_o !== 1'b0; n++) @(negedge clock_i);
    chk({7'h00, busy_o}, 8'h00);
    note("busy");
    soft_cnt = 0;
    cmd(OP_RST_EN, 2'h0);
    cmd(OP_RST, 2'h0);
    chk(8'(soft_cnt), 8'h01);
    cmd(OP_READ_STAT, 2'h1);
    chk(8'(op_cnt), 8'h00);
    repeat (SOFT_RESET_CYC) @(negedge clock_i);
    soft_cnt = 0;
    cmd(OP_RST_EN, 2'h0);
    cmd(OP_READ_STAT, 2'h1);
    chk(op_last, OP_READ_STAT);
    cmd(OP_RST, 2'h0);
    chk(8'(soft_cnt), 8'h00);
    note("soft reset");
    cmd(OP_ERASE, 2'h0);
    chk({7'h00, busy_o}, 8'h01);
    soft_cnt = 0;
    cr_cnt = 0;
    @(negedge clock_i);
    hard_reset_i = 1'b1;
    @(negedge clock_i);
    hard_reset_i = 1'b0;
    repeat (HARD_RESET_CYC + 20) @(negedge clock_i);
    chk({7'h00, busy_o}, 8'h00);
    chk(8'(cr_cnt != 0), 8'h01);
    chk(8'(soft_cnt != 0), 8'h01);
    cmd(OP_READ_STAT, 2'h1);
    chk(op_last, OP_READ_STAT);
    note("hard reset");
    close_out();
  end
endmodule : tb_serial_flash_spi_front_end
